// file: hdl/sbsf_top.sv
// spi status flags with double-buffered receive and transmit holding buffer
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "sbsf_params.svh"
module sbsf_top (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic [`SBSF_ADDR_W-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic [31:0]                  rdata,
  input  wire logic                    spi_sclk,
  input  wire logic                    spi_mosi,
  input  wire logic                    spi_cs_n,
  output logic                         spi_miso_out,
  output logic                         spi_miso_oe_n,
  input  wire logic                    err_timeout,
  input  wire logic                    err_bit_mismatch,
  input  wire logic                    err_length
);
  localparam int W = `SBSF_WORD_W;
  localparam sbsf_pkg::sbsf_core_s RST = '{rx_empty: 1'b1, default: '0};

  sbsf_pkg::sbsf_core_s st;
  sbsf_pkg::sbsf_core_s next_st;
  sbsf_link_if          lnk ();

  // address match, shared by the access decodes below; the read data mux cases on addr directly
  function automatic logic hit(input logic [`SBSF_ADDR_W-1:0] a,
                               input logic [`SBSF_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic wr_tx;
  logic wr_flags;
  logic rd_vis;
  logic rd_vec;
  logic vec_ovr;
  logic vec_rxf;
  logic disable_wr;
  logic consume;
  logic err_any;
  logic ovr_set;
  logic [31:0] flag_word;
  logic [31:0] vis_word;

  // access decode
  assign wr_tx      = wr_en & (hit(addr, `SBSF_OFF_TXA) | hit(addr, `SBSF_OFF_TXB));
  assign wr_flags   = wr_en & hit(addr, `SBSF_OFF_FLAGS);
  assign rd_vis     = rd_en & hit(addr, `SBSF_OFF_RXVIS);
  assign rd_vec     = rd_en & hit(addr, `SBSF_OFF_VEC);
  assign vec_ovr    = rd_vec & st.overrun;
  assign vec_rxf    = rd_vec & ~st.overrun & st.rx_full;
  assign disable_wr = wr_en & hit(addr, `SBSF_OFF_CTRL) & ~wdata[`SBSF_CTRL_EN];
  // visible read, vector read of a full pending or write-one clear frees the visible word
  assign consume    = rd_vis | vec_rxf | (wr_flags & wdata[`SBSF_FLG_RXF]);
  assign err_any    = err_timeout | err_bit_mismatch | err_length;

  // overrun sources: completion into a full pair, or errors over a full pair
  assign ovr_set = (lnk.rx_done & ~st.rx_empty & st.int_full & ~consume)
                 | (err_any & lnk.busy & st.int_full & ~st.rx_empty);

  // read images; fixed upper field and bit 7 ignore writes
  assign flag_word = {`SBSF_FLG_HIGH, st.tx_empty, st.rx_full, 1'b0,
                      st.overrun, 6'h00};
  assign vis_word  = {st.rx_empty, {(31 - W){1'b0}}, st.vis};

  // word offered to the shift engine from the holding buffer
  assign lnk.tx_word  = st.hold;
  assign lnk.tx_valid = st.hold_full & st.enable;

  // next state: clears first, hardware sets last so sets win
  always_comb begin
    next_st = st;

    // register read data, valid the cycle after the strobe
    next_st.rdata = 32'h00000000;
    if (rd_en) begin
      case (addr)
        `SBSF_OFF_FLAGS: next_st.rdata = flag_word;
        `SBSF_OFF_RXVIS: next_st.rdata = vis_word;
        `SBSF_OFF_EMU:   next_st.rdata = vis_word; // no side effect
        `SBSF_OFF_VEC:   next_st.rdata = st.overrun ? `SBSF_VEC_OVR :
                                         (st.rx_full ? `SBSF_VEC_RXF : `SBSF_VEC_NONE);
        `SBSF_OFF_CTRL:  next_st.rdata = {31'h00000000, st.enable};
        default:         next_st.rdata = 32'h00000000;
      endcase
    end

    // global enable
    if (wr_en && hit(addr, `SBSF_OFF_CTRL)) begin
      next_st.enable = wdata[`SBSF_CTRL_EN];
    end

    // transmit side: a write fills the holding buffer
    if (wr_tx) begin
      next_st.hold      = wdata[W-1:0];
      next_st.hold_full = 1'b1;
      next_st.tx_empty  = 1'b0;
    end
    if (disable_wr) begin
      next_st.tx_empty = 1'b0;
    end
    if (lnk.tx_take) begin
      if (!wr_tx) begin
        next_st.hold_full = 1'b0;
      end
      next_st.tx_empty = 1'b1;
    end

    // receive side: consume the visible word, refill from internal
    if (consume) begin
      next_st.rx_empty = 1'b1;
      next_st.rx_full  = 1'b0;
      if (st.int_full) begin
        next_st.vis      = st.int_data;
        next_st.int_full = 1'b0;
        next_st.rx_empty = 1'b0;
        next_st.rx_full  = 1'b1;
      end
    end
    // disable empties the receive pair so full and empty never disagree
    if (disable_wr) begin
      next_st.rx_full  = 1'b0;
      next_st.rx_empty = 1'b1;
      next_st.int_full = 1'b0;
    end

    // overrun clears only by vector read or write of one
    if (vec_ovr || (wr_flags && wdata[`SBSF_FLG_OVR])) begin
      next_st.overrun = 1'b0;
    end

    // a completed word goes to the visible register or the internal one
    if (lnk.rx_done) begin
      if (next_st.rx_empty) begin
        next_st.vis      = lnk.rx_word;
        next_st.rx_empty = 1'b0;
        next_st.rx_full  = 1'b1;
      end else begin
        next_st.int_data = lnk.rx_word; // overwrite on overrun
        next_st.int_full = 1'b1;
      end
    end
    if (ovr_set) begin
      next_st.overrun = 1'b1;
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

  // serial shift engine
  sbsf_shifter u_shift (
    .clock         (clock),
    .rst_n         (rst_n),
    .clk_en        (clk_en),
    .spi_sclk      (spi_sclk),
    .spi_mosi      (spi_mosi),
    .spi_cs_n      (spi_cs_n),
    .spi_miso_out  (spi_miso_out),
    .spi_miso_oe_n (spi_miso_oe_n),
    .lnk           (lnk)
  );

  // checks on flag behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_clear_w1_full;
    clk_en && wr_flags && wdata[`SBSF_FLG_RXF] && st.int_full;
  endsequence

  sequence s_refilled(logic [W-1:0] d);
    st.rx_full && !st.rx_empty && (st.vis == d);
  endsequence

  sequence s_flag_read;
    clk_en && rd_en && hit(addr, `SBSF_OFF_FLAGS);
  endsequence

  chk_take_sets_txe: assert property (clk_en && lnk.tx_take |=> st.tx_empty)
    else $error("transmit-empty not set after shift load");

  chk_txwr_clears_txe: assert property (clk_en && wr_tx && !lnk.tx_take
                                        |=> !st.tx_empty && st.hold_full)
    else $error("transmit-empty not cleared by data write");

  chk_done_sets_rxf: assert property (clk_en && lnk.rx_done |=> st.rx_full)
    else $error("receive-full not set after word completed");

  chk_emu_read_keeps: assert property (clk_en && rd_en && hit(addr, `SBSF_OFF_EMU)
                                       && st.rx_full |=> st.rx_full)
    else $error("emulation read changed receive-full");

  chk_w1c_refill: assert property (s_clear_w1_full |=> s_refilled($past(st.int_data)))
    else $error("write-one clear did not refill from internal buffer");

  chk_flag_fixed_bits: assert property (s_flag_read ##1 1'b1
                                        |-> rdata[31:10] == `SBSF_FLG_HIGH && !rdata[7])
    else $error("fixed flag bits read wrong");

  chk_overrun_on_full: assert property (clk_en && lnk.rx_done && !st.rx_empty
                                        && st.int_full && !consume |=> st.overrun)
    else $error("overrun not flagged on receive into full buffers");

  chk_vis_read_keeps_ovr: assert property (clk_en && rd_vis && st.overrun
                                           |=> st.overrun)
    else $error("visible read cleared overrun");

  chk_vec_clears_ovr: assert property (clk_en && vec_ovr && !ovr_set
                                       |=> !st.overrun ##1 1'b1)
    else $error("vector read did not clear overrun");

  chk_err_sets_ovr: assert property (clk_en && err_any && lnk.busy && st.int_full
                                     && !st.rx_empty |=> st.overrun)
    else $error("error over full buffers did not set overrun");

  chk_set_beats_clear: assert property (clk_en && ovr_set && wr_flags
                                        && wdata[`SBSF_FLG_OVR] |=> st.overrun)
    else $error("software clear beat hardware overrun set");
endmodule : sbsf_top

// file: pkg/sbsf_params.svh
// constants for the spi buffer status flag block
// Notes on behaviour
// - transmit-empty flag sets when a word moves into the shift register.
// - transmit-empty clears on a transmit data write or enable written 0.
// - transmit-empty 1 means holding buffer empty and fill pending, except after a data write in the same cycle as tx_take (the word stays held).
// - receive-full flag sets when a word lands in the visible receive register.
// - receive-full clears on visible read, vector read with no overrun pending, write 1, disable, reset.
// - reading the emulation mirror leaves receive-full unchanged.
// - write-1 clear sets receive-empty; a full internal buffer then refills visible.
// - flag bits 31-10 read 4000h and ignore writes.
// - flag bit 7 reads zero and ignores writes.
// - overrun sets when a receive completes while the visible and internal registers both hold unread words.
// - overrun clears only by vector read while pending or write 1.
// - reading the visible receive register does not clear overrun.
// - overruns overwrite the internal buffer; visible reads refill from it.
// - receive errors while both buffers are full and busy also set overrun.
`ifndef SBSF_PARAMS_SVH
`define SBSF_PARAMS_SVH
`define SBSF_WORD_W     16
`define SBSF_ADDR_W     8
`define SBSF_OFF_FLAGS  8'h00
`define SBSF_OFF_TXA    8'h04
`define SBSF_OFF_TXB    8'h08
`define SBSF_OFF_RXVIS  8'h0C
`define SBSF_OFF_EMU    8'h10
`define SBSF_OFF_VEC    8'h14
`define SBSF_OFF_CTRL   8'h18
`define SBSF_FLG_TXE    9
`define SBSF_FLG_RXF    8
`define SBSF_FLG_OVR    6
`define SBSF_FLG_HIGH   22'h004000
`define SBSF_RXVIS_EMP  31
`define SBSF_CTRL_EN    0
`define SBSF_VEC_NONE   32'h00000000
`define SBSF_VEC_OVR    32'h00000009
`define SBSF_VEC_RXF    32'h0000000B
`endif

// file: pkg/sbsf_pkg.sv
// types of the spi buffer status flag block
`include "sbsf_params.svh"
package sbsf_pkg;
  typedef logic [`SBSF_WORD_W-1:0] sbsf_word_t;

  // register-side state
  typedef struct packed {
    logic       enable;
    logic       tx_empty;
    logic       rx_full;
    logic       overrun;
    logic       rx_empty;
    logic       int_full;
    logic       hold_full;
    sbsf_word_t hold;
    sbsf_word_t int_data;
    sbsf_word_t vis;
    logic [31:0] rdata;
  } sbsf_core_s;

  typedef enum logic [1:0] {
    SBSF_IDLE  = 2'b01,
    SBSF_SHIFT = 2'b10
  } sbsf_fsm_e;

  // serial-side state
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       sclk_d;
    sbsf_fsm_e  fsm;
    logic [4:0] cnt;
    sbsf_word_t shreg;
    sbsf_word_t rx_word;
    logic       rx_done;
    logic       take;
    logic       miso;
  } sbsf_shift_s;
endpackage : sbsf_pkg

// file: pkg/sbsf_link_if.sv
// word hand-off between register core and shift engine
`timescale 1ns/100ps
interface sbsf_link_if;
  sbsf_pkg::sbsf_word_t tx_word;
  logic                 tx_valid;
  logic                 tx_take;
  sbsf_pkg::sbsf_word_t rx_word;
  logic                 rx_done;
  logic                 busy;

  modport core   (output tx_word, output tx_valid, input tx_take,
                  input rx_word, input rx_done, input busy);
  modport engine (input tx_word, input tx_valid, output tx_take,
                  output rx_word, output rx_done, output busy);
endinterface : sbsf_link_if

// file: hdl/sbsf_shifter.sv
// serial shift engine, spi mode 0 slave sampled on the system clock
`timescale 1ns/100ps
`include "sbsf_params.svh"
module sbsf_shifter (
  input  wire logic    clock,
  input  wire logic    rst_n,
  input  wire logic    clk_en,
  input  wire logic    spi_sclk,
  input  wire logic    spi_mosi,
  input  wire logic    spi_cs_n,
  output logic         spi_miso_out,
  output logic         spi_miso_oe_n,
  sbsf_link_if.engine  lnk
);
  localparam int W = `SBSF_WORD_W;
  // synchronisers reset to the idle pin levels: clock low, select high, so no false edge
  localparam sbsf_pkg::sbsf_shift_s RST = '{fsm: sbsf_pkg::SBSF_IDLE, sync1: 3'h1,
                                            sync2: 3'h1, default: '0};

  sbsf_pkg::sbsf_shift_s st;
  sbsf_pkg::sbsf_shift_s next_st;
  logic                  rise;
  logic                  fall;
  logic                  cs_act;

  // edge finding on the second synchroniser stage only
  assign rise   = st.sync2[2] & ~st.sclk_d;
  assign fall   = ~st.sync2[2] & st.sclk_d;
  assign cs_act = ~st.sync2[0];

  // word framing, load, shift and completion
  always_comb begin
    next_st         = st;
    next_st.rx_done = 1'b0;
    next_st.take    = 1'b0;
    next_st.sync1   = {spi_sclk, spi_mosi, spi_cs_n};
    next_st.sync2   = st.sync1;
    next_st.sclk_d  = st.sync2[2];
    case (st.fsm)
      sbsf_pkg::SBSF_IDLE: begin
        if (cs_act) begin
          next_st.shreg = lnk.tx_valid ? lnk.tx_word : '0; // zeros when nothing queued
          next_st.take  = lnk.tx_valid;
          next_st.miso  = lnk.tx_valid ? lnk.tx_word[W-1] : 1'b0;
          next_st.cnt   = '0;
          next_st.fsm   = sbsf_pkg::SBSF_SHIFT;
        end
      end
      sbsf_pkg::SBSF_SHIFT: begin
        if (!cs_act) begin
          next_st.fsm = sbsf_pkg::SBSF_IDLE; // partial word dropped
        end else if (rise) begin
          next_st.shreg = {st.shreg[W-2:0], st.sync2[1]};
          next_st.cnt   = st.cnt + 5'h01;
          if (st.cnt == 5'(W - 1)) begin
            next_st.rx_word = {st.shreg[W-2:0], st.sync2[1]};
            next_st.rx_done = 1'b1;
            next_st.fsm     = sbsf_pkg::SBSF_IDLE;
          end
        end else if (fall) begin
          next_st.miso = st.shreg[W-1];
        end
      end
      default: begin
        next_st.fsm = sbsf_pkg::SBSF_IDLE;
      end
    endcase
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign lnk.tx_take    = st.take;
  assign lnk.rx_word    = st.rx_word;
  assign lnk.rx_done    = st.rx_done;
  assign lnk.busy       = (st.fsm == sbsf_pkg::SBSF_SHIFT);
  assign spi_miso_out   = st.miso;
  assign spi_miso_oe_n  = st.sync2[0]; // driven only while selected

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_take_needs_word: assert property (st.take |-> $past(lnk.tx_valid))
    else $error("shift load took a word that was not offered");
endmodule : sbsf_shifter

// file: sim/sbsf_spi_peer.sv
// behavioural spi master on the serial side of the block
`timescale 1ns/100ps
module sbsf_spi_peer (
  output logic      spi_sclk,
  output logic      spi_mosi,
  output logic      spi_cs_n,
  input  wire logic spi_miso_out,
  input  wire logic spi_miso_oe_n
);
  logic miso_bit;

  // idle: clock parked low, chip deselected
  initial begin
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    spi_cs_n = 1'b1;
    miso_bit = 1'b0;
  end

  // one mode 0 frame, msb first; fewer than 16 bits aborts the word
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n = 1'b0;
    #48;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = tx[15-i];
      #24;
      spi_sclk = 1'b1;
      miso_bit = spi_miso_oe_n ? ~miso_bit : spi_miso_out; // released line is not trusted
      rx = {rx[14:0], miso_bit};
      #24;
      spi_sclk = 1'b0;
    end
    #24;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #48;
  endtask : xfer
endmodule : sbsf_spi_peer

// file: sim/sbsf_tb_top.sv
// self-checking bench for the spi buffer status flag block
`timescale 1ns/100ps
`include "sbsf_params.svh"
module sbsf_tb_top;
  localparam logic [7:0] a_flg = `SBSF_OFF_FLAGS;
  localparam logic [7:0] a_vis = `SBSF_OFF_RXVIS;
  localparam logic [7:0] a_vec = `SBSF_OFF_VEC;
  localparam logic [7:0] a_ctl = `SBSF_OFF_CTRL;
  logic        clock, rst_n, wr_en, rd_en;
  logic        rd_seen = 1'b0;
  logic        sclk, mosi, cs_n, miso, miso_oe_n, e_to, e_bm, e_len;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [15:0] rx, w;
  logic [15:0] m [0:7];
  logic [31:0] exp_q [$];
  int          seed, miscompares, tests_run, cycles;

  sbsf_top u_dut (
    .clock(clock), .rst_n(rst_n), .clk_en(1'b1), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_cs_n(cs_n), .spi_miso_out(miso), .spi_miso_oe_n(miso_oe_n),
    .err_timeout(e_to), .err_bit_mismatch(e_bm), .err_length(e_len)
  );

  sbsf_spi_peer u_peer (
    .spi_sclk(sclk), .spi_mosi(mosi), .spi_cs_n(cs_n),
    .spi_miso_out(miso), .spi_miso_oe_n(miso_oe_n)
  );

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // expected flag image: fixed upper field, bit 7 and low bits zero
  function automatic logic [31:0] flg(input logic t, input logic r, input logic o);
    return {22'h004000, t, r, 1'b0, o, 6'h00};
  endfunction : flg

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  // read strobe; the expected word waits in the queue for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
  endtask : rd

  task automatic frame(input logic [15:0] d);
    u_peer.xfer(d, 16, rx);
    repeat (12) @(posedge clock);
  endtask : frame

  // result watcher: data of the cycle after each read strobe
  always @(posedge clock) begin
    if (rd_seen) check(rdata, exp_q.pop_front());
    rd_seen = rd_en;
  end

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    {rst_n, wr_en, rd_en, e_to, e_bm, e_len} = 6'h00;
    addr = 8'h00;
    wdata = 32'h0;
    seed = 17;
    for (int i = 0; i < 8; i++) m[i] = $random(seed);
    w = $random(seed);
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(a_flg, flg(0, 0, 0));
    wr(a_flg, 32'hFFFFFFFF);
    rd(a_flg, flg(0, 0, 0));
    rd(8'h1C, 32'h0);
    // queued word leaves through the shift register
    wr(a_ctl, 32'h1);
    wr(`SBSF_OFF_TXA, {16'h0, w});
    rd(a_flg, flg(0, 0, 0));
    frame(m[0]);
    check({16'h0, rx}, {16'h0, w});
    rd(a_flg, flg(1, 1, 0));
    rd(`SBSF_OFF_EMU, {16'h0, m[0]});
    rd(a_flg, flg(1, 1, 0));
    rd(a_vis, {16'h0, m[0]});
    rd(a_flg, flg(1, 0, 0));
    // three words with no read between them
    for (int i = 1; i < 4; i++) frame(m[i]);
    rd(a_flg, flg(1, 1, 1));
    rd(a_vis, {16'h0, m[1]});
    rd(a_flg, flg(1, 1, 1));
    rd(a_vis, {16'h0, m[3]});
    rd(a_flg, flg(1, 0, 1));
    rd(a_vec, `SBSF_VEC_OVR);
    rd(a_flg, flg(1, 0, 0));
    rd(a_vec, `SBSF_VEC_NONE);
    // write-one clear of the full flag with the internal buffer loaded
    frame(m[4]);
    frame(m[5]);
    wr(a_flg, 32'h00000100);
    rd(a_vis, {16'h0, m[5]});
    rd(a_flg, flg(1, 0, 0));
    frame(m[6]);
    wr(a_flg, 32'h00000100);
    rd(a_flg, flg(1, 0, 0));
    rd(`SBSF_OFF_EMU, {1'b1, 15'h0, m[6]});
    frame(m[7]);
    rd(a_vis, {16'h0, m[7]});
    // receive errors while both buffers are full and a word is underway
    frame(m[1]);
    frame(m[2]);
    for (int k = 0; k < 3; k++) begin
      fork
        u_peer.xfer(m[k], 8, rx);
        begin
          repeat (40) @(posedge clock);
          {e_to, e_bm, e_len} <= 3'b100 >> k;
          @(posedge clock);
          {e_to, e_bm, e_len} <= 3'b000;
        end
      join
      repeat (12) @(posedge clock);
      rd(a_flg, flg(1, 1, 1));
      wr(a_flg, 32'h00000040);
      rd(a_flg, flg(1, 1, 0));
    end
    // second data register, then disable
    wr(`SBSF_OFF_TXB, {16'h0, ~w});
    rd(a_flg, flg(0, 1, 0));
    frame(m[4]);
    check({16'h0, rx}, {16'h0, ~w});
    rd(a_flg, flg(1, 1, 1));
    wr(a_ctl, 32'h0);
    rd(a_flg, flg(0, 0, 1));
    rd(`SBSF_OFF_EMU, {1'b1, 15'h0, m[1]});
    wr(a_ctl, 32'h1);
    frame(m[5]);
    rd(a_vec, `SBSF_VEC_OVR);
    rd(a_vec, `SBSF_VEC_RXF);
    rd(a_flg, flg(0, 0, 0));
    repeat (3) @(posedge clock);
    complete_run();
  end
endmodule : sbsf_tb_top
